// ---- hdl/cfp_pkg.sv ----
// constants and types shared by the frame lut update port
package cfp_pkg;
	// data widths
	localparam int SAMPLE_W = 16;
	localparam int MAG_W = 16;
	localparam int PHASE_W = 16;
	localparam int IDX_W = 8;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 32;

	// frame timing in cycles
	localparam int FRAME_LEN = 256;
	localparam int WINDOW_VALID = 32;
	localparam int CORDIC_ITER = 16;
	localparam int CNT_W = 9;
	localparam int ITER_W = 5;

	// slave word offsets (word index)
	localparam logic [ADDR_W-1:0] OFS_IN_MAG = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_IN_PHASE = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_OUT_MAG = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_OUT_PHASE = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_LUT_INDEX = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_WB_MAG = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_WB_PHASE = 3'h6;
	localparam logic [ADDR_W-1:0] OFS_WB_ADDR = 3'h7;

	// read data values
	localparam logic [DATA_W-1:0] INVALID_FLAG = 32'hFFFFFFFF;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

	// write-back entry: address, phase, magnitude
	localparam int WB_W = IDX_W + PHASE_W + MAG_W;
	localparam int FIFO_DEPTH = 8;

	// cordic gain 1.6468 in q2.14; not referenced, the processor model scales by gain_compensation_constant instead
	localparam logic [MAG_W-1:0] CORDIC_GAIN = 16'h6963;

	typedef enum logic [1:0] {CV_IDLE, CV_VEC_IN, CV_VEC_OUT, CV_ROT} cv_state_t;
endpackage

// ---- hdl/frame_lut_port.sv ----
// frame-scheduled polar conversion port with lut write-back queue
`timescale 1ns/100ps
//
// Overview of operation
// - at frame start, capture pa in/out samples, convert both to polar
// - polar values and lut index are readable words on the slave port
// - written polar entry converted to cartesian, stored into main lut
// - sequence repeats forever; frames run a fixed length unless a frame start cuts one short
// - external frame start input realigns the internal frame counter
// - reads inside the start window are valid once the first results have landed; later reads are invalid
// - invalid pa-in magnitude read returns all ones
// - lut index is taken from the lut_index_in pin; there is no fir sum option
// - everything runs from the one common clock
module frame_lut_port (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// frame marker pin
	input wire logic frame_start,
	// pa samples and index from the predistorter
	input wire logic signed [cfp_pkg::SAMPLE_W-1:0] pa_in_i,
	input wire logic signed [cfp_pkg::SAMPLE_W-1:0] pa_in_q,
	input wire logic signed [cfp_pkg::SAMPLE_W-1:0] pa_out_i,
	input wire logic signed [cfp_pkg::SAMPLE_W-1:0] pa_out_q,
	input wire logic [cfp_pkg::IDX_W-1:0] lut_index_in,
	// processor slave port
	input wire logic [cfp_pkg::ADDR_W-1:0] bus_addr,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [cfp_pkg::DATA_W-1:0] bus_wdata,
	output logic [cfp_pkg::DATA_W-1:0] bus_rdata,
	output logic bus_rvalid,
	output logic bus_wr_stall,
	// main lut write port
	output logic lut_we,
	output logic [cfp_pkg::IDX_W-1:0] lut_addr,
	output logic [cfp_pkg::SAMPLE_W-1:0] lut_i,
	output logic [cfp_pkg::SAMPLE_W-1:0] lut_q,
	// frame status
	output logic window_valid
);
	localparam int SW = cfp_pkg::SAMPLE_W;
	localparam int XW = cfp_pkg::SAMPLE_W + 2;

	// ------------------------------------------------------------
	// frame start synchroniser and counter
	// ------------------------------------------------------------
	logic fs_meta_r;
	logic fs_sync_r;
	logic fs_prev_r;
	logic [cfp_pkg::CNT_W-1:0] cnt_r;
	logic win_r;
	wire fs_edge = fs_sync_r && !fs_prev_r;
	wire cnt_wrap = (cnt_r == cfp_pkg::CNT_W'(cfp_pkg::FRAME_LEN - 1));
	wire frame_go = fs_edge || cnt_wrap;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fs_meta_r <= 1'b0;
			fs_sync_r <= 1'b0;
			fs_prev_r <= 1'b0;
		end else if (clk_en) begin
			fs_meta_r <= frame_start;
			fs_sync_r <= fs_meta_r;
			fs_prev_r <= fs_sync_r;
		end
	end

	// free-running fixed length frame, re-aligned by the marker
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= '0;
		end else if (clk_en) begin
			cnt_r <= frame_go ? '0 : cnt_r + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// shared cordic engine, one pass at a time
	// ------------------------------------------------------------
	cfp_pkg::cv_state_t st_r;
	logic signed [XW-1:0] x_r;
	logic signed [XW-1:0] y_r;
	logic signed [cfp_pkg::PHASE_W-1:0] z_r;
	logic [cfp_pkg::ITER_W-1:0] it_r;
	logic signed [SW-1:0] oi_r;
	logic signed [SW-1:0] oq_r;
	logic [cfp_pkg::IDX_W-1:0] idx_cap_r;
	logic [cfp_pkg::IDX_W-1:0] wb_addr_r;
	logic [cfp_pkg::MAG_W-1:0] in_mag_r;
	logic [cfp_pkg::PHASE_W-1:0] in_ph_r;
	logic [cfp_pkg::MAG_W-1:0] out_mag_r;
	logic [cfp_pkg::PHASE_W-1:0] out_ph_r;
	logic [cfp_pkg::IDX_W-1:0] idx_r;
	logic res_ok_r;
	logic cap_pend_r;
	logic [cfp_pkg::MAG_W-1:0] pin_mag_r;
	logic [cfp_pkg::PHASE_W-1:0] pin_ph_r;

	// arctan(2^-i) in phase units, pi = 2^15
	function automatic logic [cfp_pkg::PHASE_W-1:0] atan_lut(
		input logic [cfp_pkg::ITER_W-1:0] i);
		case (i)
			5'h00: atan_lut = 16'h2000;
			5'h01: atan_lut = 16'h12E4;
			5'h02: atan_lut = 16'h09FB;
			5'h03: atan_lut = 16'h0511;
			5'h04: atan_lut = 16'h028B;
			5'h05: atan_lut = 16'h0146;
			5'h06: atan_lut = 16'h00A3;
			5'h07: atan_lut = 16'h0051;
			5'h08: atan_lut = 16'h0029;
			5'h09: atan_lut = 16'h0014;
			5'h0A: atan_lut = 16'h000A;
			5'h0B: atan_lut = 16'h0005;
			5'h0C: atan_lut = 16'h0003;
			5'h0D: atan_lut = 16'h0001;
			default: atan_lut = 16'h0000;
		endcase
	endfunction

	wire vec_mode = (st_r == cfp_pkg::CV_VEC_IN) ||
		(st_r == cfp_pkg::CV_VEC_OUT);
	// vectoring drives y to zero, rotation drives z to zero
	wire dir_neg = vec_mode ? (y_r >= 0) : z_r[cfp_pkg::PHASE_W-1];
	wire signed [XW-1:0] xs = x_r >>> it_r;
	wire signed [XW-1:0] ys = y_r >>> it_r;
	wire signed [XW-1:0] x_nx = dir_neg ? x_r + ys : x_r - ys;
	wire signed [XW-1:0] y_nx = dir_neg ? y_r - xs : y_r + xs;
	wire [cfp_pkg::PHASE_W-1:0] at = atan_lut(it_r);
	wire signed [cfp_pkg::PHASE_W-1:0] z_nx = dir_neg ?
		z_r + $signed(at) : z_r - $signed(at);
	wire last_it = (it_r == cfp_pkg::ITER_W'(cfp_pkg::CORDIC_ITER - 1));
	// fold left half-plane to the right by pi so vectoring converges
	wire in_neg = oi_r < 0;
	wire signed [XW-1:0] pre_x = in_neg ? -XW'(oi_r) : XW'(oi_r);
	wire signed [XW-1:0] pre_y = in_neg ? -XW'(oq_r) : XW'(oq_r);
	wire signed [cfp_pkg::PHASE_W-1:0] pre_z = in_neg ? 16'sh8000 : 16'sh0000;

	wb_if fill_if ();
	wb_if drain_if ();
	wire [cfp_pkg::MAG_W-1:0] wb_mag = drain_if.data[cfp_pkg::MAG_W-1:0];
	wire [cfp_pkg::PHASE_W-1:0] wb_ph =
		drain_if.data[cfp_pkg::MAG_W +: cfp_pkg::PHASE_W];
	wire [cfp_pkg::IDX_W-1:0] wb_idx =
		drain_if.data[cfp_pkg::MAG_W + cfp_pkg::PHASE_W +: cfp_pkg::IDX_W];
	// frame capture has priority; write-backs wait in the fifo
	wire start_rot = (st_r == cfp_pkg::CV_IDLE) && !frame_go &&
		!cap_pend_r && drain_if.valid;
	assign drain_if.ready = clk_en && start_rot;
	wire xs_sat = x_nx[XW-1] ? 1'b0 : |x_nx[XW-2:SW-1];
	wire signed [SW-1:0] sat_x = x_nx[XW-1] ? SW'(0) : x_nx[SW-1:0];

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= cfp_pkg::CV_IDLE;
			x_r <= '0;
			y_r <= '0;
			z_r <= '0;
			it_r <= '0;
			oi_r <= '0;
			oq_r <= '0;
			idx_cap_r <= '0;
			wb_addr_r <= '0;
			in_mag_r <= '0;
			in_ph_r <= '0;
			cap_pend_r <= 1'b0;
		end else if (clk_en) begin
			case (st_r)
				cfp_pkg::CV_IDLE: begin
					it_r <= '0;
					if (frame_go || cap_pend_r) begin
						cap_pend_r <= 1'b0;
						// inputs from same-clock logic, no sync needed
						st_r <= cfp_pkg::CV_VEC_IN;
						x_r <= pa_in_i < 0 ? -XW'(pa_in_i) : XW'(pa_in_i);
						y_r <= pa_in_i < 0 ? -XW'(pa_in_q) : XW'(pa_in_q);
						z_r <= pa_in_i < 0 ? 16'sh8000 : 16'sh0000;
						oi_r <= pa_out_i;
						oq_r <= pa_out_q;
						// index taken from the pin, fir index left out
						idx_cap_r <= lut_index_in;
					end else if (start_rot) begin
						st_r <= cfp_pkg::CV_ROT;
						x_r <= XW'(wb_mag);
						y_r <= '0;
						z_r <= $signed(wb_ph);
						wb_addr_r <= wb_idx;
					end
				end
				cfp_pkg::CV_VEC_IN,
				cfp_pkg::CV_VEC_OUT,
				cfp_pkg::CV_ROT: begin
					x_r <= x_nx;
					y_r <= y_nx;
					z_r <= z_nx;
					it_r <= it_r + 1'b1;
					if (last_it && st_r == cfp_pkg::CV_VEC_IN) begin
						in_mag_r <= xs_sat ? 16'h7FFF : sat_x;
						in_ph_r <= z_nx;
						st_r <= cfp_pkg::CV_VEC_OUT;
						it_r <= '0;
						x_r <= pre_x;
						y_r <= pre_y;
						z_r <= pre_z;
					end else if (last_it) begin
						st_r <= cfp_pkg::CV_IDLE;
					end
				end
				default: st_r <= cfp_pkg::CV_IDLE;
			endcase
			// a frame start seen mid-pass is kept, never lost
			if (frame_go && st_r != cfp_pkg::CV_IDLE) begin
				cap_pend_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// presented results and lut write
	// ------------------------------------------------------------
	wire vec_out_done = (st_r == cfp_pkg::CV_VEC_OUT) && last_it;
	wire rot_done = (st_r == cfp_pkg::CV_ROT) && last_it;
	// registered window covers counter values 0 .. WINDOW_VALID-1
	wire win_now = ((cnt_r < cfp_pkg::CNT_W'(cfp_pkg::WINDOW_VALID - 1)) ||
		frame_go) && res_ok_r;

	// results latch once per frame, so the window sees one sample set
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_mag_r <= '0;
			out_ph_r <= '0;
			idx_r <= '0;
			res_ok_r <= 1'b0;
			pin_mag_r <= '0;
			pin_ph_r <= '0;
			lut_we <= 1'b0;
			lut_addr <= '0;
			lut_i <= '0;
			lut_q <= '0;
			win_r <= 1'b0;
		end else if (clk_en) begin
			win_r <= win_now;
			lut_we <= rot_done;
			if (vec_out_done) begin
				out_mag_r <= xs_sat ? 16'h7FFF : sat_x;
				out_ph_r <= z_nx;
				idx_r <= idx_cap_r;
				pin_mag_r <= in_mag_r;
				pin_ph_r <= in_ph_r;
				res_ok_r <= 1'b1;
			end else if (frame_go) begin
				// conversion takes 2*iter cycles; results land next frame
				res_ok_r <= res_ok_r;
			end
			if (rot_done) begin
				lut_addr <= wb_addr_r;
				lut_i <= x_nx[SW-1:0];
				lut_q <= y_nx[SW-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// slave port
	// ------------------------------------------------------------
	wire sel_in_mag = bus_addr == cfp_pkg::OFS_IN_MAG;
	wire sel_in_ph = bus_addr == cfp_pkg::OFS_IN_PHASE;
	wire sel_out_mag = bus_addr == cfp_pkg::OFS_OUT_MAG;
	wire sel_out_ph = bus_addr == cfp_pkg::OFS_OUT_PHASE;
	wire sel_idx = bus_addr == cfp_pkg::OFS_LUT_INDEX;
	wire [cfp_pkg::DATA_W-1:0] rd_mux =
		sel_in_mag ? cfp_pkg::DATA_W'(pin_mag_r) :
		sel_in_ph ? cfp_pkg::DATA_W'(pin_ph_r) :
		sel_out_mag ? cfp_pkg::DATA_W'(out_mag_r) :
		sel_out_ph ? cfp_pkg::DATA_W'(out_ph_r) :
		sel_idx ? cfp_pkg::DATA_W'(idx_r) :
		cfp_pkg::READ_ZERO;
	wire [cfp_pkg::DATA_W-1:0] rd_val = win_r ? rd_mux :
		cfp_pkg::INVALID_FLAG;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_rdata <= '0;
			bus_rvalid <= 1'b0;
		end else if (clk_en) begin
			bus_rvalid <= bus_rd;
			if (bus_rd) begin
				bus_rdata <= rd_val;
			end
		end
	end

	// write-back staging: magnitude and phase held, address commits
	logic [cfp_pkg::MAG_W-1:0] stg_mag_r;
	logic [cfp_pkg::PHASE_W-1:0] stg_ph_r;
	logic wb_push_r;
	logic [cfp_pkg::WB_W-1:0] wb_data_r;
	logic stall_r;
	wire wr_mag = bus_wr && bus_addr == cfp_pkg::OFS_WB_MAG;
	wire wr_ph = bus_wr && bus_addr == cfp_pkg::OFS_WB_PHASE;
	wire wr_addr = bus_wr && bus_addr == cfp_pkg::OFS_WB_ADDR;
	wire push_held = wb_push_r && !fill_if.ready;

	assign fill_if.valid = wb_push_r;
	assign fill_if.data = wb_data_r;
	assign bus_wr_stall = stall_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stg_mag_r <= '0;
			stg_ph_r <= '0;
			wb_push_r <= 1'b0;
			wb_data_r <= '0;
			stall_r <= 1'b0;
		end else if (clk_en) begin
			stall_r <= !fill_if.ready || push_held;
			if (wr_mag) begin
				stg_mag_r <= bus_wdata[cfp_pkg::MAG_W-1:0];
			end
			if (wr_ph) begin
				stg_ph_r <= bus_wdata[cfp_pkg::PHASE_W-1:0];
			end
			if (wr_addr && !push_held) begin
				wb_push_r <= 1'b1;
				wb_data_r <= {bus_wdata[cfp_pkg::IDX_W-1:0], stg_ph_r,
					stg_mag_r};
			end else if (!push_held) begin
				wb_push_r <= 1'b0;
			end
		end
	end

	wb_fifo #(
		.WIDTH(cfp_pkg::WB_W),
		.DEPTH(cfp_pkg::FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.wr(fill_if.dst),
		.rd(drain_if.src)
	);

	assign window_valid = win_r;
	// single clock domain throughout
endmodule

// ---- hdl/wb_fifo.sv ----
// synchronous fifo for write-back entries, registered read data
`timescale 1ns/100ps
module wb_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// fill side
	wb_if.dst wr,
	// drain side
	wb_if.src rd
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wp_r;
	logic [PW:0] rp_r;
	logic [WIDTH-1:0] out_r;
	logic out_vld_r;
	wire full = (wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]);
	wire empty = (wp_r == rp_r);
	wire push = wr.valid && !full;
	// output register refills when it empties or is taken
	wire load = !empty && (!out_vld_r || rd.ready);

	assign wr.ready = !full;
	assign rd.valid = out_vld_r;
	assign rd.data = out_r;

	always_ff @(posedge ref_clk) begin
		if (clk_en && push) begin
			mem[wp_r[PW-1:0]] <= wr.data;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wp_r <= '0;
			rp_r <= '0;
			out_r <= '0;
			out_vld_r <= 1'b0;
		end else if (clk_en) begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (load) begin
				out_r <= mem[rp_r[PW-1:0]];
				rp_r <= rp_r + 1'b1;
				out_vld_r <= 1'b1;
			end else if (rd.ready) begin
				out_vld_r <= 1'b0;
			end
		end
	end
endmodule

// ---- hdl/wb_if.sv ----
// valid/ready carrier for write-back entries
`timescale 1ns/100ps
interface wb_if;
	logic valid;
	logic ready;
	logic [cfp_pkg::WB_W-1:0] data;
	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface

// ---- verification/frame_lut_port_props.sv ----
// assertions on the frame lut port pins
`timescale 1ns/100ps
module frame_lut_port_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// watched pins
	input wire logic frame_start,
	input wire logic [cfp_pkg::ADDR_W-1:0] bus_addr,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [cfp_pkg::DATA_W-1:0] bus_rdata,
	input wire logic bus_rvalid,
	input wire logic bus_wr_stall,
	input wire logic lut_we,
	input wire logic window_valid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// ----
	// window length and frame spacing counters
	// ----
	logic [8:0] win_r;
	logic [9:0] gap_r;
	logic seen_r;
	// a frame start pin restarts the spacing check, it may cut a frame short
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			win_r <= 9'h000;
			gap_r <= 10'h000;
			seen_r <= 1'b0;
		end else begin
			win_r <= window_valid ? win_r + 9'h001 : 9'h000;
			gap_r <= $rose(window_valid) ? 10'h001 : gap_r + 10'h001;
			seen_r <= !frame_start && (seen_r || $rose(window_valid));
		end
	end
	sequence s_read;
		clk_en && bus_rd;
	endsequence
	sequence s_commit;
		bus_wr && bus_addr == cfp_pkg::OFS_WB_ADDR && !bus_wr_stall;
	endsequence
	// ----
	// properties
	// ----
	a_rvalid_follows: assert property (s_read |=> bus_rvalid)
		else $error("read not answered next cycle");
	a_rvalid_cause: assert property (bus_rvalid |-> $past(bus_rd))
		else $error("answer without a read");
	a_invalid_ones: assert property (s_read and !window_valid |=>
		bus_rdata == cfp_pkg::INVALID_FLAG)
		else $error("read outside window not all ones");
	a_window_mag_valid: assert property (s_read and window_valid and
		bus_addr == cfp_pkg::OFS_IN_MAG |=>
		bus_rdata != cfp_pkg::INVALID_FLAG)
		else $error("window magnitude read gave invalid value");
	a_window_len: assert property (window_valid |->
		win_r < cfp_pkg::WINDOW_VALID)
		else $error("valid window too long");
	a_frame_period: assert property ($rose(window_valid) && seen_r |->
		gap_r == cfp_pkg::FRAME_LEN)
		else $error("frame length not constant");
	a_we_single: assert property (lut_we |=> !lut_we)
		else $error("lut write longer than one cycle");
	a_we_after_commit: assert property (s_commit |-> ##[1:600] lut_we)
		else $error("committed entry never stored");
endmodule

// ---- verification/frame_lut_port_tb.sv ----
// self-checking bench for the frame lut port
`timescale 1ns/100ps
module frame_lut_port_tb;
	logic ref_clk, sys_rst, frame_start, bus_rd, bus_wr, bus_rvalid;
	logic bus_wr_stall, lut_we, window_valid, stall_seen, hit, clk_en;
	logic [2:0] bus_addr;
	logic [31:0] bus_wdata, bus_rdata, d;
	logic [7:0] lut_addr;
	logic [15:0] lut_i, lut_q;
	logic [4:0][31:0] v;
	logic [39:0] we_q[$];
	int err_count = 0;
	int cmp_count = 0;
	frame_lut_port u_frame_lut_port (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .frame_start(frame_start), .pa_in_i(16'sh1000),
		.pa_in_q(16'sh0000), .pa_out_i(16'sh0000), .pa_out_q(16'sh1000),
		.lut_index_in(8'h5A), .bus_addr(bus_addr), .bus_rd(bus_rd),
		.bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.bus_rvalid(bus_rvalid), .bus_wr_stall(bus_wr_stall),
		.lut_we(lut_we), .lut_addr(lut_addr), .lut_i(lut_i), .lut_q(lut_q),
		.window_valid(window_valid));
	proc_model u_proc_model (.ref_clk(ref_clk), .bus_addr(bus_addr),
		.bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
		.bus_wr_stall(bus_wr_stall));
	// ----
	// compares and monitors
	// ----
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// conversions are approximate, so results may miss by up to 32 lsb
	task automatic near(input string n, input logic [15:0] e,
		input logic [15:0] g);
		int df;
		df = int'($signed(g)) - int'($signed(e));
		cmp_count++;
		if ($isunknown(g) || df > 32 || df < -32) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	always @(negedge ref_clk) begin
		if (lut_we === 1'b1)
			we_q.push_back({lut_addr, lut_i, lut_q});
		if (bus_wr_stall === 1'b1)
			stall_seen = 1'b1;
	end
	task automatic wait_we(input int n);
		for (int c = 0; c < 2000 && we_q.size() < n; c++)
			@(negedge ref_clk);
		chk("lut write count", 32'(n), 32'(we_q.size()));
	endtask
	task automatic chk_we(input int k, input logic [7:0] a, input logic ph);
		chk("lut addr", {24'h000000, a}, {24'h000000, we_q[k][39:32]});
		near("lut i", ph ? 16'h0000 : 16'h2000, we_q[k][31:16]);
		near("lut q", ph ? 16'h2000 : 16'h0000, we_q[k][15:0]);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_invalid;
		logic ok;
		chk("reset outs", 32'h0, {28'h0, lut_we, bus_rvalid, window_valid,
			bus_wr_stall});
		u_proc_model.rd(cfp_pkg::OFS_IN_MAG, d, ok);
		chk("early mag", cfp_pkg::INVALID_FLAG, d);
		repeat (40) @(negedge ref_clk);
		u_proc_model.rd(cfp_pkg::OFS_IN_PHASE, d, ok);
		chk("late phase", cfp_pkg::INVALID_FLAG, d);
		$display("test invalid done");
	endtask
	task automatic t_sync;
		logic ok;
		u_proc_model.sync(v, hit);
		chk("sync hit", 32'h1, {31'h0, hit});
		near("in mag", 16'h1A59, v[0][15:0]);
		near("in phase", 16'h0000, v[1][15:0]);
		near("out mag", v[0][15:0], v[2][15:0]);
		near("out phase", 16'h4000, v[3][15:0]);
		chk("index", 32'h0000005A, v[4]);
		u_proc_model.rd(cfp_pkg::OFS_IN_MAG, d, ok);
		chk("mag stable", v[0], d);
		$display("test sync done");
	endtask
	task automatic t_single;
		we_q.delete();
		u_proc_model.wb(16'h2000, 16'h0000, v[4][7:0]);
		u_proc_model.rel();
		wait_we(1);
		if (we_q.size() > 0)
			chk_we(0, v[4][7:0], 1'b0);
		$display("test single done");
	endtask
	task automatic t_queue;
		we_q.delete();
		stall_seen = 1'b0;
		for (int k = 0; k < 12; k++)
			u_proc_model.wb(16'h2000, k[0] ? 16'h4000 : 16'h0000, 8'(k + 16));
		u_proc_model.rel();
		wait_we(12);
		chk("stall seen", 32'h1, {31'h0, stall_seen});
		for (int k = 0; k < 12 && k < we_q.size(); k++)
			chk_we(k, 8'(k + 16), k[0]);
		$display("test queue done");
	endtask
	task automatic t_realign;
		int n;
		for (n = 0; n < 600 && window_valid !== 1'b0; n++)
			@(negedge ref_clk);
		repeat (40) @(negedge ref_clk);
		frame_start = 1'b1;
		for (n = 0; n < 300 && window_valid !== 1'b1; n++) begin
			@(negedge ref_clk);
			if (n == 1)
				frame_start = 1'b0;
		end
		chk("realign delay", 32'h1, {31'h0, n >= 3 && n <= 6});
		repeat (600) @(negedge ref_clk);
		$display("test realign done");
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (30000) @(posedge ref_clk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		frame_start = 1'b0;
		stall_seen = 1'b0;
		repeat (12) @(negedge ref_clk);
		sys_rst = 1'b0;
		t_invalid();
		t_sync();
		t_single();
		t_queue();
		t_realign();
		tally_and_finish();
	end
endmodule
bind frame_lut_port frame_lut_port_props u_frame_lut_port_props (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.frame_start(frame_start), .bus_addr(bus_addr), .bus_rd(bus_rd),
	.bus_wr(bus_wr), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
	.bus_wr_stall(bus_wr_stall), .lut_we(lut_we),
	.window_valid(window_valid));

// ---- verification/proc_model.sv ----
// processor model on the slave bus of the frame lut port
`timescale 1ns/100ps
module proc_model #(
	parameter logic [15:0] gain_compensation_constant = 16'h26DC
) (
	// clock
	input wire logic ref_clk,
	// slave bus
	output logic [cfp_pkg::ADDR_W-1:0] bus_addr,
	output logic bus_rd,
	output logic bus_wr,
	output logic [cfp_pkg::DATA_W-1:0] bus_wdata,
	input wire logic [cfp_pkg::DATA_W-1:0] bus_rdata,
	input wire logic bus_rvalid,
	input wire logic bus_wr_stall
);
	// ----
	// bus cycles
	// ----
	logic [15:0] polar_copy [256];
	initial begin
		bus_addr = 3'h0;
		bus_rd = 1'b0;
		bus_wr = 1'b0;
		bus_wdata = 32'h00000000;
	end
	// released lines show the inverse so stale values are never trusted
	task automatic rd(input logic [2:0] a, output logic [31:0] d,
		output logic ok);
		@(negedge ref_clk);
		bus_wr = 1'b0;
		bus_rd = 1'b1;
		bus_addr = a;
		@(negedge ref_clk);
		ok = bus_rvalid;
		d = bus_rdata;
		bus_rd = 1'b0;
		bus_addr = ~a;
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(negedge ref_clk);
		while (bus_wr_stall !== 1'b0) begin
			bus_wr = 1'b0;
			@(negedge ref_clk);
		end
		bus_wr = 1'b1;
		bus_addr = a;
		bus_wdata = d;
		@(posedge ref_clk);
	endtask
	task automatic rel;
		@(negedge ref_clk);
		bus_wr = 1'b0;
		bus_addr = ~bus_addr;
		bus_wdata = ~bus_wdata;
	endtask
	task automatic sync(output logic [4:0][31:0] v, output logic hit);
		logic ok;
		hit = 1'b0;
		for (int n = 0; n < 400 && !hit; n++) begin
			rd(cfp_pkg::OFS_IN_MAG, v[0], ok);
			hit = ok && (v[0] !== cfp_pkg::INVALID_FLAG);
		end
		for (int k = 1; k < 5; k++)
			rd(3'(k), v[k], ok);
	endtask
	task automatic wb(input logic [15:0] mag, input logic [15:0] ph,
		input logic [7:0] idx);
		logic [31:0] sc;
		sc = ({16'h0000, mag} * {16'h0000, gain_compensation_constant}) >> 14;
		polar_copy[idx] = sc[15:0];
		wr(cfp_pkg::OFS_WB_MAG, sc);
		wr(cfp_pkg::OFS_WB_PHASE, {16'h0000, ph});
		wr(cfp_pkg::OFS_WB_ADDR, {24'h000000, idx});
	endtask
endmodule
